// [inc/crx_pkg.sv]
// How it works
// - Error passive entry posts warning code 3ff6200B
// - Counter above 255 enters bus off, halts
// - Bus off makes reads return BFF6200B
// - Missing ack counts up, never bus off
// - Type field; type 0 data frame
// - Identifier standard 11-bit unless extended flagged
// - Type 1 remote: count is DLC, no data
// - Type 2 only if logging on, passive
// - Type 2 ident encodes severity and cause
// - Clearing problems emits ident 0000000B record
package crx_pkg;
  localparam logic [31:0] TYPE_DATA = 32'h0000_0000;
  localparam logic [31:0] TYPE_REMOTE = 32'h0000_0001;
  localparam logic [31:0] TYPE_COMM = 32'h0000_0002;
  localparam logic [31:0] CODE_OK = 32'h0000_0000;
  localparam logic [31:0] CODE_PASSIVE_WARN = 32'h3FF6_200B;
  localparam logic [31:0] CODE_BUSOFF_ERR = 32'hBFF6_200B;
  localparam logic [31:0] COMM_CLEARED = 32'h0000_000B;
  localparam logic [3:0] SEV_ERROR = 4'h8;
  localparam logic [3:0] SEV_WARN = 4'h4;
  localparam logic [7:0] COMM_LOW = 8'h0B;
  localparam logic [7:0] CAUSE_GENERAL = 8'h00;
  localparam logic [7:0] CAUSE_STUFF = 8'h01;
  localparam logic [7:0] CAUSE_FORMAT = 8'h02;
  localparam logic [7:0] CAUSE_NOACK = 8'h03;
  localparam logic [8:0] TEC_PASSIVE = 9'h080;
  localparam logic [8:0] TEC_BUSOFF = 9'h100;
  localparam logic [8:0] TEC_NOACK_CAP = 9'h080;
  localparam logic [8:0] TEC_ERR_STEP = 9'h008;
  localparam logic [10:0] STD_ID_MASK = 11'h7FF;
  localparam int REC_W = 32 + 32 + 32 + 64;
  localparam logic [0:0] EXT_BIT_POS = 1'h0;
  localparam int EXT_FLAG_BIT = 31;
  typedef enum logic [1:0] {CRX_ACTIVE, CRX_PASSIVE, CRX_BUSOFF} crx_state_t;
endpackage : crx_pkg

// [rtl/crx_buf2.sv]
`timescale 1ns/10ps
// Two-entry buffer; full throughput with a registered ready
module crx_buf2 #(
  parameter int W = 160
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic do_wr;
  logic do_rd;

  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];

  // Storage and pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (do_wr) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (do_rd) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end

  // A third word would overwrite one that the reader has not taken yet
  property p_no_overfill;
    @(posedge clk) disable iff (!rst_n)
    count_reg <= 2'h2;
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("buffer overfilled");
endmodule : crx_buf2

// [rtl/crx_top.sv]
`timescale 1ns/10ps
// Receive record builder and fault-confinement tracker
module crx_top
  import crx_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  // Received frame strobe from the protocol engine (same clock)
  input wire logic RX_STB,
  input wire logic RX_REMOTE,
  input wire logic RX_EXT,
  input wire logic [28:0] RX_ID,
  input wire logic [3:0] RX_DLC,
  input wire logic [63:0] RX_DATA,
  // Transmit outcome pulses
  input wire logic TX_NOACK,
  input wire logic TX_ERR,
  input wire logic TX_OK,
  // Communication problem pulses
  input wire logic COMM_EVT,
  input wire logic COMM_IS_ERR,
  input wire logic [7:0] COMM_CAUSE,
  input wire logic COMM_CLEAR,
  // Logging enable from a pin
  input wire logic LOG_COMM_PIN,
  // Record output stream
  output logic REC_VALID,
  input wire logic REC_READY,
  output logic [31:0] REC_TYPE,
  output logic [31:0] REC_IDENT,
  output logic [31:0] REC_COUNT,
  output logic [63:0] REC_DATA,
  output logic [31:0] READ_STATUS,
  output logic BUS_HALT,
  output logic [8:0] TEC,
  output logic RX_LOST
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser for the pin input
  logic log_meta_reg;
  logic log_sync_reg;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      log_meta_reg <= 1'b0;
      log_sync_reg <= 1'b0;
    end else begin
      log_meta_reg <= LOG_COMM_PIN;
      log_sync_reg <= log_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault confinement
  crx_state_t state_reg;
  logic [8:0] tec_reg;
  logic [8:0] tec_next;
  logic halted;
  assign halted = (state_reg == CRX_BUSOFF);

  // Counter update; a missing ack stops counting at the passive limit
  always_comb begin
    tec_next = tec_reg;
    if (!halted) begin
      if (TX_ERR) begin
        tec_next = tec_reg + TEC_ERR_STEP;
      end else if (TX_NOACK) begin
        if (tec_reg < TEC_NOACK_CAP) begin
          tec_next = tec_reg + 9'h001;
        end
      end else if (TX_OK && tec_reg != 9'h000) begin
        tec_next = tec_reg - 9'h001;
      end
      if (TX_ERR && tec_reg >= (TEC_BUSOFF - TEC_ERR_STEP)) begin
        tec_next = TEC_BUSOFF; // Saturate at bus off, no wrap
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tec_reg <= 9'h000;
    end else begin
      tec_reg <= tec_next;
    end
  end

  // State follows the counter; bus off is final until reset
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= CRX_ACTIVE;
    end else begin
      case (state_reg)
        CRX_ACTIVE: begin
          if (tec_next >= TEC_BUSOFF) begin
            state_reg <= CRX_BUSOFF;
          end else if (tec_next >= TEC_PASSIVE) begin
            state_reg <= CRX_PASSIVE;
          end
        end
        CRX_PASSIVE: begin
          if (tec_next >= TEC_BUSOFF) begin
            state_reg <= CRX_BUSOFF;
          end else if (tec_next < TEC_PASSIVE) begin
            state_reg <= CRX_ACTIVE;
          end
        end
        CRX_BUSOFF: state_reg <= CRX_BUSOFF;
        default: state_reg <= CRX_ACTIVE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read status: warning on passive entry, fatal once bus off
  logic [31:0] status_reg;
  logic enter_passive;
  assign enter_passive = (state_reg == CRX_ACTIVE) && (tec_next >= TEC_PASSIVE)
                         && (tec_next < TEC_BUSOFF);
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_reg <= CODE_OK;
    end else if (halted || tec_next >= TEC_BUSOFF) begin
      status_reg <= CODE_BUSOFF_ERR;
    end else if (enter_passive) begin
      status_reg <= CODE_PASSIVE_WARN;
    end else if (REC_VALID && REC_READY && status_reg == CODE_PASSIVE_WARN) begin
      status_reg <= CODE_OK; // Warning is reported by one read only
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Record formatting
  function automatic logic [31:0] comm_ident(input logic is_err, input logic [7:0] cause);
    comm_ident = {(is_err ? SEV_ERROR : SEV_WARN), 4'h0, cause, 8'h00, COMM_LOW};
  endfunction : comm_ident

  function automatic logic [31:0] frame_ident(input logic ext, input logic [28:0] id);
    if (ext) begin
      frame_ident = {1'b1, 2'b00, id};
    end else begin
      frame_ident = {21'h0, id[10:0] & STD_ID_MASK};
    end
  endfunction : frame_ident

  logic cand_valid;
  logic [REC_W-1:0] cand_rec;
  logic comm_ok;
  logic in_ready;
  logic problem_reg;
  assign comm_ok = log_sync_reg && (state_reg == CRX_PASSIVE);

  // One source per cycle; state records win over frames in the same cycle
  always_comb begin
    cand_valid = 1'b0;
    cand_rec = '0;
    if (comm_ok && COMM_EVT) begin
      cand_valid = 1'b1;
      cand_rec = {TYPE_COMM, comm_ident(COMM_IS_ERR, COMM_CAUSE), 32'h0, 64'h0};
    end else if (comm_ok && COMM_CLEAR && problem_reg) begin
      cand_valid = 1'b1;
      cand_rec = {TYPE_COMM, COMM_CLEARED, 32'h0, 64'h0};
    end else if (RX_STB && !halted) begin
      cand_valid = 1'b1;
      if (RX_REMOTE) begin
        cand_rec = {TYPE_REMOTE, frame_ident(RX_EXT, RX_ID), 28'h0, RX_DLC, 64'h0};
      end else begin
        cand_rec = {TYPE_DATA, frame_ident(RX_EXT, RX_ID), 28'h0, RX_DLC, RX_DATA};
      end
    end
  end

  // Outstanding problem flag, set wins over clear
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      problem_reg <= 1'b0;
    end else if (comm_ok && COMM_EVT) begin
      problem_reg <= 1'b1;
    end else if (comm_ok && COMM_CLEAR) begin
      problem_reg <= 1'b0;
    end
  end

  // Lost-word flag when buffer is full; sticky until reset
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RX_LOST <= 1'b0;
    end else if (cand_valid && !in_ready) begin
      RX_LOST <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer and output registers
  logic buf_valid;
  logic [REC_W-1:0] buf_data;
  logic buf_ready;
  crx_buf2 #(.W(REC_W)) u_buf (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .in_valid(cand_valid),
    .in_ready(in_ready),
    .in_data(cand_rec),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // Output stage refills when empty or when the host takes the word
  assign buf_ready = !REC_VALID || REC_READY;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REC_VALID <= 1'b0;
      REC_TYPE <= 32'h0;
      REC_IDENT <= 32'h0;
      REC_COUNT <= 32'h0;
      REC_DATA <= 64'h0;
    end else if (buf_ready) begin
      REC_VALID <= buf_valid;
      if (buf_valid) begin
        {REC_TYPE, REC_IDENT, REC_COUNT, REC_DATA} <= buf_data;
      end
    end
  end

  // Mirrors of internal state
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      READ_STATUS <= CODE_OK;
      BUS_HALT <= 1'b0;
      TEC <= 9'h000;
    end else begin
      READ_STATUS <= status_reg;
      BUS_HALT <= halted; // Transmitter must stop while high
      TEC <= tec_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_busoff_entry;
    @(posedge REF_CLK) disable iff (!RESETN)
    (tec_next >= TEC_BUSOFF) |=> (state_reg == CRX_BUSOFF);
  endproperty
  a_busoff_entry: assert property (p_busoff_entry) else $error("no bus off");

  property p_busoff_status;
    @(posedge REF_CLK) disable iff (!RESETN)
    (state_reg == CRX_BUSOFF) |=> ##1 (READ_STATUS == CODE_BUSOFF_ERR);
  endproperty
  a_busoff_status: assert property (p_busoff_status) else $error("bad fatal code");

  property p_passive_warn;
    @(posedge REF_CLK) disable iff (!RESETN)
    enter_passive |=> (status_reg == CODE_PASSIVE_WARN);
  endproperty
  a_passive_warn: assert property (p_passive_warn) else $error("no passive code");

  property p_noack_safe;
    @(posedge REF_CLK) disable iff (!RESETN)
    (TX_NOACK && !TX_ERR && !halted)
      |=> (!halted && (tec_reg <= TEC_NOACK_CAP || tec_reg == $past(tec_reg)));
  endproperty
  a_noack_safe: assert property (p_noack_safe) else $error("noack overrun");

  // No new record enters the buffer once communication has stopped
  property p_busoff_quiet;
    @(posedge REF_CLK) disable iff (!RESETN)
    halted |-> !cand_valid;
  endproperty
  a_busoff_quiet: assert property (p_busoff_quiet) else $error("record in bus off");

  // The counter saturates exactly at the bus off level
  property p_halt_tec;
    @(posedge REF_CLK) disable iff (!RESETN)
    BUS_HALT |-> (TEC == TEC_BUSOFF);
  endproperty
  a_halt_tec: assert property (p_halt_tec) else $error("bus off counter");

  // A zero severity nibble is only ever the cleared record
  property p_clear_code;
    @(posedge REF_CLK) disable iff (!RESETN)
    (REC_VALID && REC_TYPE == TYPE_COMM && REC_IDENT[31:28] == 4'h0)
      |-> (REC_IDENT == COMM_CLEARED);
  endproperty
  a_clear_code: assert property (p_clear_code) else $error("bad cleared ident");

  property p_comm_gate;
    @(posedge REF_CLK) disable iff (!RESETN)
    (cand_valid && cand_rec[REC_W-1 -: 32] == TYPE_COMM) |-> comm_ok;
  endproperty
  a_comm_gate: assert property (p_comm_gate) else $error("comm record ungated");

  property p_std_id;
    @(posedge REF_CLK) disable iff (!RESETN)
    (RX_STB && !RX_EXT && cand_rec[REC_W-1 -: 32] != TYPE_COMM && cand_valid)
      |-> (cand_rec[127:107] == 21'h0);
  endproperty
  a_std_id: assert property (p_std_id) else $error("std id too wide");

  property p_remote_nodata;
    @(posedge REF_CLK) disable iff (!RESETN)
    (REC_VALID && REC_TYPE == TYPE_REMOTE) |-> (REC_DATA == 64'h0);
  endproperty
  a_remote_nodata: assert property (p_remote_nodata) else $error("remote data");

  property p_comm_low;
    @(posedge REF_CLK) disable iff (!RESETN)
    (REC_VALID && REC_TYPE == TYPE_COMM) |-> (REC_IDENT[7:0] == COMM_LOW);
  endproperty
  a_comm_low: assert property (p_comm_low) else $error("comm ident low byte");

  property p_stall_hold;
    @(posedge REF_CLK) disable iff (!RESETN)
    (REC_VALID && !REC_READY) |=> (REC_VALID && $stable(REC_IDENT));
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("record dropped");
endmodule : crx_top

// [test/can_rx_record_and_error_state_tb.sv]
`timescale 1ns/10ps
module can_rx_record_and_error_state_tb;
  import crx_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
  logic REF_CLK = 0, RESETN = 0, RX_STB = 0, RX_REMOTE = 0, RX_EXT = 0;
  logic [28:0] RX_ID = 0;
  logic [3:0] RX_DLC = 0;
  logic [63:0] RX_DATA = 0;
  logic TX_NOACK = 0, TX_ERR = 0, TX_OK = 0, COMM_EVT = 0, COMM_IS_ERR = 0;
  logic [7:0] COMM_CAUSE = 0;
  logic COMM_CLEAR = 0, LOG_COMM_PIN = 0, slow = 1, rdy;
  logic REC_VALID, BUS_HALT, RX_LOST;
  logic [31:0] REC_TYPE, REC_IDENT, REC_COUNT, READ_STATUS;
  logic [63:0] REC_DATA;
  logic [8:0] TEC;
  logic [159:0] got[$], exp[$];
  int n_errors = 0, n_checks = 0;
  crx_top dut_u (.REF_CLK(REF_CLK), .RESETN(RESETN), .RX_STB(RX_STB), .RX_REMOTE(RX_REMOTE),
    .RX_EXT(RX_EXT), .RX_ID(RX_ID), .RX_DLC(RX_DLC), .RX_DATA(RX_DATA), .TX_NOACK(TX_NOACK),
    .TX_ERR(TX_ERR), .TX_OK(TX_OK), .COMM_EVT(COMM_EVT), .COMM_IS_ERR(COMM_IS_ERR),
    .COMM_CAUSE(COMM_CAUSE), .COMM_CLEAR(COMM_CLEAR), .LOG_COMM_PIN(LOG_COMM_PIN),
    .REC_VALID(REC_VALID), .REC_READY(rdy), .REC_TYPE(REC_TYPE), .REC_IDENT(REC_IDENT),
    .REC_COUNT(REC_COUNT), .REC_DATA(REC_DATA), .READ_STATUS(READ_STATUS),
    .BUS_HALT(BUS_HALT), .TEC(TEC), .RX_LOST(RX_LOST));
  crx_reader host_u (.clk(REF_CLK), .rst_n(RESETN), .slow(slow), .rdy(rdy));
  always #5 REF_CLK = ~REF_CLK;
  // Capture taken records; fields that a record type leaves unused are masked
  always @(posedge REF_CLK) begin
    if (REC_VALID && rdy) begin
      got.push_back({REC_TYPE, REC_IDENT, (REC_TYPE == TYPE_COMM) ? 32'h0 : REC_COUNT,
        (REC_TYPE == TYPE_DATA) ? REC_DATA : 64'h0});
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge REF_CLK);
    #1;
  endtask : tick
  task automatic pulse(ref logic s, input int n);
    repeat (n) begin
      s = 1'b1;
      tick();
      s = 1'b0;
      tick();
    end
  endtask : pulse
  // Expected frame record: standard ident unless the extended flag is set
  task automatic frame(input logic rem, ext, logic [28:0] id, logic [3:0] dlc, logic [63:0] d);
    RX_REMOTE = rem;
    RX_EXT = ext;
    RX_ID = id;
    RX_DLC = dlc;
    RX_DATA = d;
    RX_STB = 1'b1;
    tick();
    RX_STB = 1'b0;
    tick(); // Idle edge so the strobe never falls and rises in one step
    exp.push_back({rem ? TYPE_REMOTE : TYPE_DATA, ext ? {3'h4, id} : {21'h0, id[10:0]},
      {28'h0, dlc}, rem ? 64'h0 : d});
  endtask : frame
  task automatic comm(input logic e, logic [7:0] c);
    COMM_IS_ERR = e;
    COMM_CAUSE = c;
    pulse(COMM_EVT, 1);
    exp.push_back({TYPE_COMM, e ? SEV_ERROR : SEV_WARN, 4'h0, c, 16'h000B, 96'h0});
  endtask : comm
  task automatic drain();
    logic [159:0] g;
    for (int k = 0; k < 300 && got.size() < exp.size(); k++) tick();
    repeat (8) tick();
    `CHK(got.size(), exp.size())
    while (exp.size() > 0 && got.size() > 0) begin
      g = got.pop_front();
      `CHK(g, exp.pop_front())
    end
    got.delete();
    exp.delete();
  endtask : drain
  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need about a thousand cycles, this allows 50000 (some fiftyfold)
  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32));
    repeat (4) tick();
    RESETN = 1'b1;
    tick();
    // Random frames in threes, one idle edge apart, queue up under stall
    for (int i = 0; i < 8; i++) begin
      repeat (3) frame(1'b0, $urandom % 2, $urandom, $urandom % 9, {$urandom, $urandom});
      drain();
    end
    frame(1'b0, 1'b1, 29'h1FFFFFFF, 4'h8, 64'hFEDCBA9876543210);
    frame(1'b0, 1'b0, 29'h1FFFF800, 4'h0, 64'h0);
    drain();
    `CHK(RX_LOST, 1'b0)
    $display("test data frames done");
    for (int d = 0; d < 16; d++) begin
      frame(1'b1, d % 2, $urandom, d[3:0], {$urandom, $urandom});
      drain();
    end
    $display("test remote frames done");
    // Active state: problem events make no record even with logging on
    slow = 1'b0;
    LOG_COMM_PIN = 1'b1;
    repeat (4) tick();
    COMM_IS_ERR = 1'b1;
    pulse(COMM_EVT, 1);
    drain();
    pulse(TX_NOACK, 3);
    pulse(TX_OK, 1);
    `CHK(TEC, 9'h002)
    pulse(TX_NOACK, 200);
    `CHK(TEC, TEC_PASSIVE)
    `CHK(BUS_HALT, 1'b0)
    `CHK(READ_STATUS, CODE_PASSIVE_WARN)
    $display("test missing ack done");
    // Passive, logging off: still no record
    LOG_COMM_PIN = 1'b0;
    repeat (4) tick();
    pulse(COMM_EVT, 1);
    drain();
    LOG_COMM_PIN = 1'b1;
    repeat (4) tick();
    for (int i = 0; i < 8; i++) begin
      comm(i[2], i[1:0]);
      drain();
    end
    `CHK(READ_STATUS, CODE_OK)
    pulse(COMM_CLEAR, 1);
    exp.push_back({TYPE_COMM, COMM_CLEARED, 96'h0});
    drain();
    // A second clear with nothing outstanding makes no record
    pulse(COMM_CLEAR, 1);
    drain();
    // Problem record and frame back to back must keep their order
    slow = 1'b1;
    comm(1'b0, CAUSE_STUFF);
    frame(1'b0, 1'b0, 29'h123, 4'h2, 64'hA5A5);
    drain();
    $display("test comm records done");
    pulse(TX_ERR, 20);
    `CHK(TEC, TEC_BUSOFF)
    `CHK(BUS_HALT, 1'b1)
    `CHK(READ_STATUS, CODE_BUSOFF_ERR)
    RX_STB = 1'b1;
    tick();
    RX_STB = 1'b0;
    drain();
    `CHK(READ_STATUS, CODE_BUSOFF_ERR)
    $display("test bus off done");
    end_sim();
  end
endmodule : can_rx_record_and_error_state_tb

// [test/crx_reader.sv]
`timescale 1ns/10ps
// Host reader model: takes records promptly or with random stalls
module crx_reader (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  output logic rdy
);
  // Stalls make the buffer hold words, so a lost or repeated word shows up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy <= 1'b0;
    end else begin
      rdy <= !slow || ($urandom % 3 == 0);
    end
  end
endmodule : crx_reader
